/* File: logic/wdt_defines.svh */
// Register offsets, field positions and reset values of the two-stage watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define WDT_LOAD_OFS 8'h00
`define WDT_VALUE_OFS 8'h04
`define WDT_CTL_OFS 8'h08
`define WDT_ICR_OFS 8'h0c
`define WDT_RIS_OFS 8'h10
`define WDT_MIS_OFS 8'h14
`define WDT_LOCK_OFS 8'h18
`define WDT_INTEN_OFS 8'h1c

// ****************************************************************
// Control field positions
// ****************************************************************
`define WDT_CTL_EN_BIT 0
`define WDT_CTL_RESEN_BIT 1
`define WDT_CTL_STALL_BIT 2

// ****************************************************************
// Reset values and keys
// ****************************************************************
`define WDT_LOAD_RST 32'hffffffff
`define WDT_UNLOCK_KEY 32'h1acce551

`endif

/* File: logic/wdt_pkg.sv */
// Types shared by the watchdog design files
package wdt_pkg;
	typedef logic [7:0] addr_t;
	typedef logic [31:0] word_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FIRST = 3'b010,
		ST_SECOND = 3'b100
	} wdt_state_t;
endpackage

/* File: logic/wdt_counter.sv */
// Loadable 32-bit down counter with zero detection
`timescale 1ns/1ps
module wdt_counter #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_val,
	input wire logic dec,
	output logic [WIDTH-1:0] count,
	output logic at_zero
);
	// Load has priority; decrement stops at zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '1;
		end else if (load) begin
			count <= load_val;
		end else if (dec && count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign at_zero = (count == '0);
endmodule

/* File: logic/wdt_top.sv */
// Two-stage watchdog: register port, timeout state machine, interrupt and reset
`timescale 1ns/1ps
`include "wdt_defines.svh"
module wdt_top (
	clk,
	arst_n,
	addr,
	wdata,
	wr_en,
	rd_en,
	rdata,
	dbg_halt,
	irq,
	sys_rst
);
	input wire logic clk;
	input wire logic arst_n;
	input wire wdt_pkg::addr_t addr;
	input wire wdt_pkg::word_t wdata;
	input wire logic wr_en;
	input wire logic rd_en;
	output wdt_pkg::word_t rdata;
	input wire logic dbg_halt;
	output logic irq;
	output logic sys_rst;
	import wdt_pkg::*;

	// ****************************************************************
	// Storage
	// ****************************************************************
	word_t load_reg;
	logic en_reg;
	logic resen_reg;
	logic stall_reg;
	logic lock_reg;
	logic inten_reg;
	logic ris_reg;
	logic irq_reg;
	logic rst_reg;
	word_t rdata_reg;
	wdt_state_t state_reg;
	wdt_state_t state_next;
	logic halt_s1_reg;
	logic halt_s2_reg;
	word_t count;
	logic at_zero;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	// Register select, shared by the write decode and the read mux
	function automatic logic addr_hit(input addr_t a, input addr_t ofs);
		return a == ofs;
	endfunction

	wire logic wr_load = wr_en && addr_hit(addr, `WDT_LOAD_OFS);
	wire logic wr_ctl = wr_en && addr_hit(addr, `WDT_CTL_OFS);
	wire logic wr_icr = wr_en && addr_hit(addr, `WDT_ICR_OFS);
	wire logic wr_lock = wr_en && addr_hit(addr, `WDT_LOCK_OFS);
	wire logic wr_inten = wr_en && addr_hit(addr, `WDT_INTEN_OFS);
	wire logic cfg_ok = !lock_reg;
	wire logic load_wr_ok = wr_load && cfg_ok;
	wire logic ctl_wr_ok = wr_ctl && cfg_ok;
	wire logic inten_wr_ok = wr_inten && cfg_ok;
	// enabling the counter arms the interrupt
	wire logic en_new = ctl_wr_ok && wdata[`WDT_CTL_EN_BIT];
	wire logic en_eff = en_reg || en_new;
	wire logic mis = ris_reg && inten_reg;

	// ****************************************************************
	// Debug halt synchroniser
	// ****************************************************************
	// Halt comes from the debug logic, outside our timing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			halt_s1_reg <= 1'b0;
			halt_s2_reg <= 1'b0;
		end else begin
			halt_s1_reg <= dbg_halt;
			halt_s2_reg <= halt_s1_reg;
		end
	end

	// ****************************************************************
	// Counter
	// ****************************************************************
	// stall the count while the debugger halts the core
	wire logic stalled = stall_reg && halt_s2_reg;
	// counting runs only while enabled and not stalled
	wire logic cnt_dec = en_reg && !stalled;
	// Timeout event when the running counter sits at zero
	wire logic timeout = cnt_dec && at_zero;
	// a new load value is taken immediately
	wire logic cnt_load = load_wr_ok || timeout || wr_icr;
	wire word_t cnt_val = load_wr_ok ? wdata : load_reg;

	wdt_counter #(
		.WIDTH(32)
	) u_counter (
		.clk(clk),
		.arst_n(arst_n),
		.load(cnt_load),
		.load_val(cnt_val),
		.dec(cnt_dec),
		.count(count),
		.at_zero(at_zero)
	);

	// ****************************************************************
	// Timeout state machine
	// ****************************************************************
	// first timeout raises the interrupt
	// zero load value raises the interrupt at once
	wire logic zero_load = load_wr_ok && wdata == 32'h00000000;
	wire logic first_evt = (timeout && !ris_reg) || (zero_load && en_eff);
	// second zero while the second stage is armed and reset enabled
	// The second stage is entered with the status bit and left only by a clear,
	// so it stands for a first timeout that software has not yet answered
	wire logic second_stage = (state_reg == ST_SECOND);
	wire logic second_evt = timeout && second_stage && resen_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (first_evt) begin
					state_next = ST_SECOND;
				end else if (en_new) begin
					state_next = ST_FIRST;
				end
			end
			ST_FIRST: begin
				if (first_evt) begin
					state_next = ST_SECOND;
				end
			end
			ST_SECOND: begin
				// cleared in time means back to first stage
				// Mirrors the status flag: a same-cycle event keeps the stage
				if (wr_icr && !first_evt) begin
					state_next = ST_FIRST;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	// load value stored and readable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			load_reg <= `WDT_LOAD_RST;
		end else if (load_wr_ok) begin
			load_reg <= wdata;
		end
	end

	// reset enable and stall controls; enable is sticky until reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			en_reg <= 1'b0;
			resen_reg <= 1'b0;
			stall_reg <= 1'b0;
		end else if (ctl_wr_ok) begin
			en_reg <= en_reg | wdata[`WDT_CTL_EN_BIT];
			resen_reg <= wdata[`WDT_CTL_RESEN_BIT];
			stall_reg <= wdata[`WDT_CTL_STALL_BIT];
		end
	end

	// interrupt enable set by enable or its own register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inten_reg <= 1'b0;
		end else if (en_new || (inten_wr_ok && wdata[0])) begin
			inten_reg <= 1'b1;
		end
	end

	// unlock key opens, any other value locks
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_reg <= 1'b0;
		end else if (wr_lock) begin
			lock_reg <= (wdata != `WDT_UNLOCK_KEY);
		end
	end

	// ****************************************************************
	// Interrupt status and outputs
	// ****************************************************************
	// clear drops the source; a same-cycle event wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ris_reg <= 1'b0;
		end else if (first_evt) begin
			ris_reg <= 1'b1;
		end else if (wr_icr) begin
			ris_reg <= 1'b0;
		end
	end

	// Output flops: interrupt follows masked status, reset is sticky
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_reg <= 1'b0;
			rst_reg <= 1'b0;
		end else begin
			irq_reg <= mis;
			rst_reg <= rst_reg | second_evt;
		end
	end

	assign irq = irq_reg;
	assign sys_rst = rst_reg;

	// ****************************************************************
	// Read port
	// ****************************************************************
	// lock reads one while locked
	wire word_t rd_mux =
		addr_hit(addr, `WDT_LOAD_OFS) ? load_reg :
		addr_hit(addr, `WDT_VALUE_OFS) ? count :
		addr_hit(addr, `WDT_CTL_OFS) ? {29'h0, stall_reg, resen_reg, en_reg} :
		addr_hit(addr, `WDT_RIS_OFS) ? {31'h0, ris_reg} :
		addr_hit(addr, `WDT_MIS_OFS) ? {31'h0, mis} :
		addr_hit(addr, `WDT_LOCK_OFS) ? {31'h0, lock_reg} :
		addr_hit(addr, `WDT_INTEN_OFS) ? {31'h0, inten_reg} : 32'h00000000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 32'h00000000;
		end else if (rd_en) begin
			rdata_reg <= rd_mux;
		end else begin
			rdata_reg <= 32'h00000000;
		end
	end

	assign rdata = rdata_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_lock_blocks_load: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_load && lock_reg) |=> load_reg == $past(load_reg))
		else $error("load changed while locked");

	a_first_sets_ris: assert property (@(posedge clk) disable iff (!arst_n)
		(timeout && !ris_reg) |=> ris_reg)
		else $error("first timeout did not set status");

	a_enable_arms_int: assert property (@(posedge clk) disable iff (!arst_n)
		en_new |=> inten_reg && en_reg)
		else $error("enable did not arm interrupt");

	a_reload_after_zero: assert property (@(posedge clk) disable iff (!arst_n)
		(timeout && !load_wr_ok) |=> count == $past(load_reg))
		else $error("counter not reloaded");

	a_second_resets: assert property (@(posedge clk) disable iff (!arst_n)
		(timeout && ris_reg && resen_reg) |=> ##1 sys_rst)
		else $error("second timeout gave no reset");

	a_no_reset_disabled: assert property (@(posedge clk) disable iff (!arst_n)
		(!resen_reg && !sys_rst) |=> ##1 !sys_rst || $past(resen_reg))
		else $error("reset without enable");

	a_load_immediate: assert property (@(posedge clk) disable iff (!arst_n)
		load_wr_ok |=> count == $past(wdata))
		else $error("load write not taken");

	a_clear_drops_irq: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_icr && !first_evt) |=> !ris_reg ##1 !irq)
		else $error("clear did not drop interrupt");

	a_zero_load_irq: assert property (@(posedge clk) disable iff (!arst_n)
		(zero_load && en_eff) |=> ris_reg)
		else $error("zero load gave no interrupt");

	a_stall_holds: assert property (@(posedge clk) disable iff (!arst_n)
		(stalled && !cnt_load) |=> count == $past(count))
		else $error("counter moved while stalled");

	a_unlock_opens: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_lock && wdata == `WDT_UNLOCK_KEY) |=> !lock_reg)
		else $error("unlock failed");

	// ****************************************************************
	// Stage, status, reload, lock and output checks
	// ****************************************************************
	// Stage register and status flag must never drift apart
	a_stage_tracks_status: assert property (@(posedge clk) disable iff (!arst_n)
		second_stage == ris_reg)
		else $error("timeout stage and status disagree");

	// Exactly one stage at a time
	a_state_one_hot: assert property (@(posedge clk) disable iff (!arst_n)
		$onehot(state_reg))
		else $error("timeout state not one-hot");

	// A clear restarts the count from the stored value
	a_clear_reloads: assert property (@(posedge clk) disable iff (!arst_n)
		wr_icr |=> count == $past(load_reg))
		else $error("clear did not reload counter");

	// Control bits hold while locked
	a_locked_ctl_holds: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_ctl && lock_reg) |=> en_reg == $past(en_reg) &&
			resen_reg == $past(resen_reg) && stall_reg == $past(stall_reg))
		else $error("control changed while locked");

	// Interrupt output only from an enabled, set status
	a_irq_needs_status: assert property (@(posedge clk) disable iff (!arst_n)
		irq |-> $past(ris_reg) && $past(inten_reg))
		else $error("interrupt without masked status");

	// An enabled, set status reaches the output one cycle later
	a_irq_follows_status: assert property (@(posedge clk) disable iff (!arst_n)
		(ris_reg && inten_reg) |=> irq)
		else $error("masked status did not raise interrupt");

	// Read data is zero outside the cycle after a read strobe
	a_read_data_idle: assert property (@(posedge clk) disable iff (!arst_n)
		!rd_en |=> rdata == 32'h00000000)
		else $error("read data outside read cycle");
endmodule

/* File: bench/irq_rst_model.sv */
// Processor interrupt input and system reset catcher facing the watchdog
`timescale 1ns/1ps
module irq_rst_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic irq,
	input wire logic sys_rst,
	output int irq_edges,
	output logic rst_seen
);
	logic irq_reg;
	// Count handler entries on each rising interrupt and latch any reset request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_reg <= 1'b0;
			irq_edges <= 0;
			rst_seen <= 1'b0;
		end else begin
			irq_reg <= irq;
			if (irq && !irq_reg) irq_edges <= irq_edges + 1;
			if (sys_rst) rst_seen <= 1'b1;
		end
	end
endmodule

/* File: bench/tb_wdt_top.sv */
// Self-checking bench for the two-stage watchdog
`timescale 1ns/1ps
`include "wdt_defines.svh"
module tb_wdt_top;
	import wdt_pkg::*;
	logic clk, arst_n, wr_en, rd_en, dbg_halt, irq, sys_rst, rst_seen;
	addr_t addr;
	word_t wdata, rdata, v1, v2;
	int irq_edges, errors, checks;

	wdt_top i_wdt_top (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .dbg_halt(dbg_halt), .irq(irq), .sys_rst(sys_rst));
	irq_rst_model i_irq_rst_model (.clk(clk), .arst_n(arst_n), .irq(irq), .sys_rst(sys_rst),
		.irq_edges(irq_edges), .rst_seen(rst_seen));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Register port cycles and comparisons
	task wr(input addr_t a, input word_t d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task rd(input addr_t a, output word_t d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rdata;
	endtask
	task chk(input word_t got, input word_t exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rng(input word_t got, input word_t lo, input word_t hi);
		checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp<=%h", $time, got, hi);
		end
	endtask
	task rchk(input addr_t a, input word_t exp);
		word_t d;
		rd(a, d);
		chk(d, exp);
	endtask
	// Bounded wait for irq (s=0) or sys_rst (s=1)
	task wait_hi(input bit s, input int n);
		#1;
		for (int i = 0; i < n; i++) begin
			if (s ? sys_rst : irq) break;
			@(posedge clk);
			#1;
		end
		chk({31'h0, s ? sys_rst : irq}, 32'h1);
	endtask
	task test_done;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard, far beyond the expected run length
	initial begin
		#100000;
		errors++;
		test_done;
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		arst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		dbg_halt = 1'b0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		rchk(`WDT_LOAD_OFS, `WDT_LOAD_RST);
		rchk(`WDT_VALUE_OFS, 32'hffffffff);
		rchk(`WDT_CTL_OFS, 32'h0);
		rchk(`WDT_RIS_OFS, 32'h0);
		rchk(`WDT_LOCK_OFS, 32'h0);
		wr(8'h20, 32'h1);
		rchk(8'h20, 32'h0);
		rchk(`WDT_LOAD_OFS, `WDT_LOAD_RST);
		$display("test reset values done");
		wr(`WDT_LOAD_OFS, 32'h14);
		rchk(`WDT_LOAD_OFS, 32'h14);
		wr(`WDT_CTL_OFS, 32'h1);
		wait_hi(1'b0, 40);
		rchk(`WDT_RIS_OFS, 32'h1);
		rchk(`WDT_MIS_OFS, 32'h1);
		rd(`WDT_VALUE_OFS, v1);
		rng(v1, 32'h8, 32'h14);
		chk(irq_edges, 32'h1);
		wr(`WDT_ICR_OFS, 32'h1);
		repeat (2) @(posedge clk);
		#1;
		chk({31'h0, irq}, 32'h0);
		rchk(`WDT_RIS_OFS, 32'h0);
		rchk(`WDT_MIS_OFS, 32'h0);
		wr(`WDT_LOAD_OFS, 32'h3e8);
		rd(`WDT_VALUE_OFS, v1);
		rng(v1, 32'h3e0, 32'h3e8);
		$display("test first timeout done");
		wr(`WDT_CTL_OFS, 32'h5);
		@(posedge clk) dbg_halt <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`WDT_VALUE_OFS, v1);
		repeat (8) @(posedge clk);
		rd(`WDT_VALUE_OFS, v2);
		chk(v2, v1);
		wr(`WDT_CTL_OFS, 32'h1);
		repeat (4) @(posedge clk);
		rd(`WDT_VALUE_OFS, v1);
		repeat (8) @(posedge clk);
		rd(`WDT_VALUE_OFS, v2);
		rng(v1 - v2, 32'h9, 32'hb);
		@(posedge clk) dbg_halt <= 1'b0;
		$display("test debug stall done");
		wr(`WDT_LOCK_OFS, 32'h0);
		rchk(`WDT_LOCK_OFS, 32'h1);
		wr(`WDT_LOAD_OFS, 32'h5);
		wr(`WDT_CTL_OFS, 32'h7);
		rchk(`WDT_LOAD_OFS, 32'h3e8);
		rchk(`WDT_CTL_OFS, 32'h1);
		wr(`WDT_LOCK_OFS, `WDT_UNLOCK_KEY);
		rchk(`WDT_LOCK_OFS, 32'h0);
		$display("test lock done");
		wr(`WDT_LOAD_OFS, 32'h1e);
		wr(`WDT_CTL_OFS, 32'h3);
		wait_hi(1'b0, 50);
		chk({31'h0, sys_rst}, 32'h0);
		wait_hi(1'b1, 50);
		@(posedge clk);
		#1;
		chk({31'h0, rst_seen}, 32'h1);
		@(posedge clk) arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk({31'h0, sys_rst}, 32'h0);
		arst_n <= 1'b1;
		wr(`WDT_CTL_OFS, 32'h1);
		#1;
		chk({31'h0, irq}, 32'h0);
		wr(`WDT_LOAD_OFS, 32'h0);
		wait_hi(1'b0, 4);
		$display("test second timeout done");
		test_done;
	end
endmodule
